// ==== core/tda_cfg.svh ====
// constants for the time-of-day accumulator
`ifndef TDA_CFG_SVH
`define TDA_CFG_SVH
`define TDA_SEC_W    48
`define TDA_NS_W     32
`define TDA_SUB_W    8
`define TDA_TOD_W    88
`define TDA_NS_MAX   32'h3B9AC9FF
`define TDA_TOD_RST  88'h0
`define TDA_FIFO_DEP 4
`define TDA_FIFO_AW  2
`define TDA_NUM_EVT  4
`define TDA_EVT_SYNC 0
`define TDA_EVT_GPIO 1
`define TDA_EVT_IRQ  2
`define TDA_EVT_GTMR 3
`endif

// ==== core/tda_pkg.sv ====
// types shared by the time-of-day accumulator modules
package tda_pkg;
  typedef enum logic [1:0] {
    TDA_RATE_500,
    TDA_RATE_625,
    TDA_RATE_OTHER
  } tda_rate_t;
  typedef enum logic [2:0] {
    TDA_LD_NONE,
    TDA_LD_SYNC,
    TDA_LD_GTMR,
    TDA_LD_CSR,
    TDA_LD_PWM
  } tda_load_src_t;
  typedef enum logic [2:0] {
    TDA_LT_NONE,
    TDA_LT_PPS,
    TDA_LT_SYNC,
    TDA_LT_GPIO,
    TDA_LT_GTMR,
    TDA_LT_CSR,
    TDA_LT_IRQ
  } tda_latch_src_t;
endpackage

// ==== core/tda_step_if.sv ====
// fractional step signals between accumulator and modulus counter
`timescale 1ns/1ps
`default_nettype none
interface tda_step_if;
  logic [15:0] fracNum;
  logic [15:0] fracDen;
  logic        stepEn;
  logic        fracCarry;
  modport owner (output fracNum, output fracDen, output stepEn,
                 input fracCarry);
  modport acc (input fracNum, input fracDen, input stepEn,
               output fracCarry);
endinterface
`default_nettype wire

// ==== core/tda_edge_detect.sv ====
// rising edge detector for the event inputs
`timescale 1ns/1ps
`default_nettype none
`include "tda_cfg.svh"
module tda_edge_detect
  import tda_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [`TDA_NUM_EVT-1:0] level,
  output logic      [`TDA_NUM_EVT-1:0] rise
);
  logic [`TDA_NUM_EVT-1:0] prev_q;
  logic [`TDA_NUM_EVT-1:0] prev_d;

  // active edge is low to high
  always_comb begin
    prev_d = level;
    rise   = level & ~prev_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule
`default_nettype wire

// ==== core/tda_frac_acc.sv ====
// flexible modulus accumulator for the sub-ns remainder
`timescale 1ns/1ps
`default_nettype none
module tda_frac_acc
  import tda_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  tda_step_if.acc   stepBus
);
  logic [15:0] resid_q;
  logic [15:0] resid_d;
  logic [16:0] sum;

  // remainder carries forward instead of truncating
  always_comb begin
    sum               = {1'b0, resid_q} + {1'b0, stepBus.fracNum};
    resid_d           = resid_q;
    stepBus.fracCarry = 1'b0;
    if (stepBus.stepEn && (stepBus.fracDen != 16'h0)) begin
      if (sum >= {1'b0, stepBus.fracDen}) begin
        resid_d           = 16'(sum - {1'b0, stepBus.fracDen});
        stepBus.fracCarry = 1'b1;
      end else begin
        resid_d = sum[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resid_q <= 16'h0;
    end else begin
      resid_q <= resid_d;
    end
  end
endmodule
`default_nettype wire

// ==== core/tda_accumulator.sv ====
// time-of-day accumulator with load, latch, capture FIFO and PWM hooks
`timescale 1ns/1ps
`default_nettype none
`include "tda_cfg.svh"
module tda_accumulator
  import tda_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire tda_rate_t             rateFamily,
  input  wire logic [15:0]           rateM,
  input  wire logic [15:0]           rateN,
  input  wire logic [1:0]            channelId,
  input  wire logic [7:0]            incNs,
  input  wire logic [7:0]            incSub,
  input  wire logic [15:0]           fracNum,
  input  wire logic [15:0]           fracDen,
  input  wire logic [`TDA_TOD_W-1:0] loadValue,
  input  wire logic                  hostLoadWrite,
  input  wire logic                  hostLatchRead,
  input  wire tda_load_src_t         loadSel,
  input  wire tda_latch_src_t        latchSel,
  input  wire logic                  extSync,
  input  wire logic                  gpioIn,
  input  wire logic                  gpioIrq,
  input  wire logic                  globalTimerExp,
  input  wire logic                  csrWrite,
  input  wire logic                  csrRead,
  input  wire logic                  pwmLoadValid,
  input  wire logic [`TDA_TOD_W-1:0] pwmLoadValue,
  input  wire logic                  fifoPop,
  output logic      [`TDA_TOD_W-1:0] todNow_q,
  output logic      [`TDA_TOD_W-1:0] latchValue_q,
  output logic                       latchValid_q,
  output logic                       ppsOut_q,
  output logic      [`TDA_TOD_W-1:0] pwmValue_q,
  output logic                       pwmValid_q,
  output logic      [`TDA_TOD_W-1:0] fifoData_q,
  output logic                       fifoDataValid_q,
  output logic      [2:0]            fifoCount_q,
  output logic                       cycleMode_q
);

  // true when the clock rate lets the accumulator count real time
  function automatic logic tdaRateOk(
    input tda_rate_t   fam,
    input logic [15:0] m,
    input logic [15:0] n,
    input logic [1:0]  ch
  );
    logic [19:0] m20;
    logic [19:0] n20;
    logic        fast;
    m20  = {4'h0, m};
    n20  = {4'h0, n};
    fast = (ch < 2'h2);
    tdaRateOk = 1'b0;
    case (fam)
      TDA_RATE_500: begin
        if (fast) begin
          tdaRateOk = (n != 16'h0) && (m20 >= n20) &&
                      (m20 <= 20'(n20 * 20'h2));
        end else begin
          tdaRateOk = (n != 16'h0) && (m20 >= n20) &&
                      (20'(m20 * 20'h2) <= 20'(n20 * 20'h3));
        end
      end
      TDA_RATE_625: begin
        if (m[15:8] != 8'h0 || n[15:8] != 8'h0 || n == 16'h0) begin
          tdaRateOk = 1'b0;
        end else if (fast) begin
          tdaRateOk = (m20 >= n20) &&
                      (20'(m20 * 20'h5) <= 20'(n20 * 20'h8));
        end else begin
          tdaRateOk = (m20 >= n20) &&
                      (20'(m20 * 20'h5) <= 20'(n20 * 20'h6));
        end
      end
      default: begin
        tdaRateOk = 1'b0;
      end
    endcase
  endfunction

  tda_step_if stepBus ();
  logic [`TDA_NUM_EVT-1:0] evtLevel;
  logic [`TDA_NUM_EVT-1:0] evtRise;

  // edge detection of the external event inputs
  assign evtLevel[`TDA_EVT_SYNC] = extSync;
  assign evtLevel[`TDA_EVT_GPIO] = gpioIn;
  assign evtLevel[`TDA_EVT_IRQ]  = gpioIrq;
  assign evtLevel[`TDA_EVT_GTMR] = globalTimerExp;

  tda_edge_detect uEdge (
    .clk    (clk),
    .arst_n (arst_n),
    .level  (evtLevel),
    .rise   (evtRise)
  );

  // fractional remainder only steps in real-time mode
  assign stepBus.fracNum = fracNum;
  assign stepBus.fracDen = fracDen;
  assign stepBus.stepEn  = !cycleMode_q;

  tda_frac_acc uFrac (
    .clk     (clk),
    .arst_n  (arst_n),
    .stepBus (stepBus)
  );

  logic [`TDA_SEC_W-1:0] sec_q;
  logic [`TDA_NS_W-1:0]  ns_q;
  logic [`TDA_SUB_W-1:0] sub_q;
  logic [`TDA_SEC_W-1:0] sec_d;
  logic [`TDA_NS_W-1:0]  ns_d;
  logic [`TDA_SUB_W-1:0] sub_d;
  logic                  cycleMode_d;
  logic [8:0]            subSum;
  logic [33:0]           nsSum;
  logic                  secCarry;
  logic                  loadEvt;
  logic [`TDA_TOD_W-1:0] loadSrc;
  logic [`TDA_TOD_W-1:0] todCur;

  assign todCur = {sec_q, ns_q, sub_q};

  // load source: host write of seconds top byte or selected trigger
  always_comb begin
    loadEvt = hostLoadWrite;
    loadSrc = loadValue;
    case (loadSel)
      TDA_LD_SYNC: loadEvt = loadEvt | evtRise[`TDA_EVT_SYNC];
      TDA_LD_GTMR: loadEvt = loadEvt | evtRise[`TDA_EVT_GTMR];
      TDA_LD_CSR:  loadEvt = loadEvt | csrWrite;
      TDA_LD_PWM: begin
        if (pwmLoadValid) begin
          loadEvt = 1'b1;
          loadSrc = pwmLoadValue;
        end
      end
      default: loadEvt = hostLoadWrite;
    endcase
  end

  // time advance by one period per divider clock
  always_comb begin
    cycleMode_d = !tdaRateOk(rateFamily, rateM, rateN, channelId);
    subSum   = 9'({1'b0, sub_q} + {1'b0, incSub}) +
               {8'h0, stepBus.fracCarry};
    nsSum    = {2'b00, ns_q} + {26'h0, incNs} + {33'h0, subSum[8]};
    secCarry = 1'b0;
    sec_d    = sec_q;
    ns_d     = ns_q;
    sub_d    = sub_q;
    if (loadEvt) begin
      sec_d = loadSrc[87:40];
      ns_d  = loadSrc[39:8];
      sub_d = cycleMode_q ? 8'h00 : loadSrc[7:0];
    end else if (cycleMode_q) begin
      ns_d  = ns_q + 32'h1;
      sub_d = 8'h00;
      if (ns_q == 32'hFFFFFFFF) begin
        secCarry = 1'b1;
        sec_d    = sec_q + 48'h1;
      end
    end else begin
      sub_d = subSum[7:0];
      if (nsSum > {2'b00, `TDA_NS_MAX}) begin
        ns_d     = 32'(nsSum - 34'h3B9ACA00);
        secCarry = 1'b1;
        sec_d    = sec_q + 48'h1;
      end else begin
        ns_d = nsSum[31:0];
      end
    end
  end

  // accumulator state, clocked by the divider clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_q       <= '0;
      ns_q        <= '0;
      sub_q       <= '0;
      cycleMode_q <= 1'b1;
    end else begin
      sec_q       <= sec_d;
      ns_q        <= ns_d;
      sub_q       <= sub_d;
      cycleMode_q <= cycleMode_d;
    end
  end

  logic                  latchEvt;
  logic                  pushEvt;
  logic [`TDA_TOD_W-1:0] todNow_d;
  logic [`TDA_TOD_W-1:0] latchValue_d;
  logic                  latchValid_d;
  logic                  ppsOut_d;
  logic [`TDA_TOD_W-1:0] pwmValue_d;
  logic                  pwmValid_d;

  // latch source: host read of preceding word or selected event; a selected sync edge pushes the capture FIFO instead
  always_comb begin
    latchEvt = hostLatchRead;
    pushEvt  = 1'b0;
    case (latchSel)
      TDA_LT_PPS:  latchEvt = latchEvt | ppsOut_q;
      TDA_LT_SYNC: pushEvt  = evtRise[`TDA_EVT_SYNC];
      TDA_LT_GPIO: latchEvt = latchEvt | evtRise[`TDA_EVT_GPIO];
      TDA_LT_GTMR: latchEvt = latchEvt | evtRise[`TDA_EVT_GTMR];
      TDA_LT_CSR:  latchEvt = latchEvt | csrRead;
      TDA_LT_IRQ:  latchEvt = latchEvt | evtRise[`TDA_EVT_IRQ];
      default:     latchEvt = hostLatchRead;
    endcase
    todNow_d     = {sec_d, ns_d, sub_d};
    latchValue_d = latchEvt ? todCur : latchValue_q;
    latchValid_d = latchEvt;
    ppsOut_d     = secCarry;
    pwmValue_d   = ppsOut_q ? todCur : pwmValue_q;
    pwmValid_d   = ppsOut_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      todNow_q     <= `TDA_TOD_RST;
      latchValue_q <= `TDA_TOD_RST;
      latchValid_q <= 1'b0;
      ppsOut_q     <= 1'b0;
      pwmValue_q   <= `TDA_TOD_RST;
      pwmValid_q   <= 1'b0;
    end else begin
      todNow_q     <= todNow_d;
      latchValue_q <= latchValue_d;
      latchValid_q <= latchValid_d;
      ppsOut_q     <= ppsOut_d;
      pwmValue_q   <= pwmValue_d;
      pwmValid_q   <= pwmValid_d;
    end
  end

  logic [`TDA_TOD_W-1:0]   fifoMem_q [`TDA_FIFO_DEP];
  logic [`TDA_FIFO_AW-1:0] wrPtr_q;
  logic [`TDA_FIFO_AW-1:0] rdPtr_q;
  logic [`TDA_FIFO_AW-1:0] wrPtr_d;
  logic [`TDA_FIFO_AW-1:0] rdPtr_d;
  logic [2:0]              fifoCount_d;
  logic [`TDA_TOD_W-1:0]   fifoData_d;
  logic                    fifoDataValid_d;
  logic                    doPush;
  logic                    doPop;

  // capture FIFO; a push into a full FIFO is dropped
  always_comb begin
    doPush          = pushEvt && (fifoCount_q != 3'h4);
    doPop           = fifoPop && (fifoCount_q != 3'h0);
    wrPtr_d         = doPush ? wrPtr_q + 2'h1 : wrPtr_q;
    rdPtr_d         = doPop ? rdPtr_q + 2'h1 : rdPtr_q;
    fifoCount_d     = fifoCount_q + {2'b00, doPush} - {2'b00, doPop};
    fifoData_d      = doPop ? fifoMem_q[rdPtr_q] : fifoData_q;
    fifoDataValid_d = doPop;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q         <= '0;
      rdPtr_q         <= '0;
      fifoCount_q     <= 3'h0;
      fifoData_q      <= `TDA_TOD_RST;
      fifoDataValid_q <= 1'b0;
      for (int i = 0; i < `TDA_FIFO_DEP; i++) begin
        fifoMem_q[i] <= `TDA_TOD_RST;
      end
    end else begin
      wrPtr_q         <= wrPtr_d;
      rdPtr_q         <= rdPtr_d;
      fifoCount_q     <= fifoCount_d;
      fifoData_q      <= fifoData_d;
      fifoDataValid_q <= fifoDataValid_d;
      if (doPush) begin
        fifoMem_q[wrPtr_q] <= todCur;
      end
    end
  end

  // checks of the accumulator behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seqFree;
    !loadEvt && !cycleMode_q && (nsSum > {2'b00, `TDA_NS_MAX});
  endsequence

  // seconds step and pps in one cycle, pwm send-out one cycle later
  sequence seqSecStep;
    (sec_q == $past(sec_q) + 48'h1) && ppsOut_q ##1 pwmValid_q;
  endsequence

  chk_ns_range: assert property (
    !cycleMode_q && !$past(loadEvt) |-> ns_q <= `TDA_NS_MAX)
    else $error("ns field beyond one second");

  chk_sub_zero: assert property (
    cycleMode_q |=> sub_q == 8'h00)
    else $error("sub-ns nonzero in cycle mode");

  chk_cycle_step: assert property (
    cycleMode_q && !loadEvt && ns_q != 32'hFFFFFFFF
      |=> ns_q == $past(ns_q) + 32'h1 && sec_q == $past(sec_q))
    else $error("cycle counter did not step by one");

  chk_sec_carry: assert property (
    seqFree |=> seqSecStep)
    else $error("ns rollover lost the seconds carry");

  chk_load_value: assert property (
    hostLoadWrite && !cycleMode_q |=> todCur == $past(loadValue))
    else $error("host load not applied");

  chk_host_latch: assert property (
    hostLatchRead |=> latchValid_q && latchValue_q == $past(todCur))
    else $error("host read did not latch time");

  chk_fifo_push: assert property (
    pushEvt && fifoCount_q < 3'h4 && !fifoPop
      |=> fifoCount_q == $past(fifoCount_q) + 3'h1)
    else $error("sync pulse not captured");

  chk_pwm_send: assert property (
    ppsOut_q |=> pwmValid_q && pwmValue_q == $past(todCur))
    else $error("pulse per second value not sent");

endmodule
`default_nettype wire

// ==== testbench/tda_event_src.sv ====
// event source model: sync pulse, gpio, irq and global timer lines
`timescale 1ns/1ps
`default_nettype none
`include "tda_cfg.svh"
module tda_event_src
  import tda_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [`TDA_NUM_EVT-1:0] fire,
  output logic      [`TDA_NUM_EVT-1:0] level
);
  logic [1:0] holdCnt_q [`TDA_NUM_EVT];

  // a fired line stays high three cycles, so each shot is one clean edge
  always_ff @(posedge clk or negedge arst_n) begin
    for (int i = 0; i < `TDA_NUM_EVT; i++) begin
      if (!arst_n) begin
        holdCnt_q[i] <= 2'h0;
      end else if (fire[i]) begin
        holdCnt_q[i] <= 2'h3;
      end else if (holdCnt_q[i] != 2'h0) begin
        holdCnt_q[i] <= holdCnt_q[i] - 2'h1;
      end
    end
  end

  // lines rest low between shots
  always_comb begin
    for (int i = 0; i < `TDA_NUM_EVT; i++) level[i] = holdCnt_q[i] != 2'h0;
  end
endmodule
`default_nettype wire

// ==== testbench/time_of_day_accumulator_tb_top.sv ====
// self-checking bench for the time-of-day accumulator
`timescale 1ns/1ps
`default_nettype none
`include "tda_cfg.svh"
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin errorCnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
`define WAIT(c) begin waitN = 0; \
  while ((c) !== 1'b1 && waitN < 20) begin @(posedge clk); #1; waitN++; end \
  if ((c) !== 1'b1) begin errorCnt++; stopTest(); end end
module time_of_day_accumulator_tb_top
  import tda_pkg::*;
;
  logic                  clk, arstN;
  tda_rate_t             rateFamily;
  logic [15:0]           rateM, rateN, fracNum, fracDen;
  logic [1:0]            channelId;
  logic [7:0]            incNs, incSub;
  logic [`TDA_TOD_W-1:0] loadValue, pwmLoadValue;
  logic                  hostLoadWrite, hostLatchRead, csrWrite, csrRead;
  tda_load_src_t         loadSel;
  tda_latch_src_t        latchSel;
  logic [3:0]            fire, evt;
  logic                  pwmLoadValid, fifoPop;
  logic [`TDA_TOD_W-1:0] todNow_q, latchValue_q, pwmValue_q, fifoData_q;
  logic                  latchValid_q, ppsOut_q, pwmValid_q;
  logic                  fifoDataValid_q, cycleMode_q;
  logic [2:0]            fifoCount_q;
  int                    errorCnt, cmpCount, waitN;

  tda_accumulator i_tda_accumulator (
    .clk(clk), .arst_n(arstN), .rateFamily(rateFamily), .rateM(rateM),
    .rateN(rateN), .channelId(channelId), .incNs(incNs), .incSub(incSub),
    .fracNum(fracNum), .fracDen(fracDen), .loadValue(loadValue),
    .hostLoadWrite(hostLoadWrite), .hostLatchRead(hostLatchRead),
    .loadSel(loadSel), .latchSel(latchSel),
    .extSync(evt[`TDA_EVT_SYNC]), .gpioIn(evt[`TDA_EVT_GPIO]),
    .gpioIrq(evt[`TDA_EVT_IRQ]), .globalTimerExp(evt[`TDA_EVT_GTMR]),
    .csrWrite(csrWrite), .csrRead(csrRead), .pwmLoadValid(pwmLoadValid),
    .pwmLoadValue(pwmLoadValue), .fifoPop(fifoPop), .todNow_q(todNow_q),
    .latchValue_q(latchValue_q), .latchValid_q(latchValid_q),
    .ppsOut_q(ppsOut_q), .pwmValue_q(pwmValue_q), .pwmValid_q(pwmValid_q),
    .fifoData_q(fifoData_q), .fifoDataValid_q(fifoDataValid_q),
    .fifoCount_q(fifoCount_q), .cycleMode_q(cycleMode_q)
  );

  tda_event_src i_tda_event_src (
    .clk(clk), .arst_n(arstN), .fire(fire), .level(evt)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stopTest();
    if (errorCnt == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic shoot(input int k);
    @(posedge clk) fire <= 4'h1 << k;
    @(posedge clk) fire <= 4'h0;
    #1;
  endtask

  // one load through host, csr or pwm path; lands at the taking edge
  task automatic loadVia(input int kind, input logic [87:0] v);
    @(posedge clk);
    loadValue <= v;
    pwmLoadValue <= v;
    case (kind)
      0: hostLoadWrite <= 1'b1;
      1: begin csrWrite <= 1'b1; loadSel <= TDA_LD_CSR; end
      default: begin pwmLoadValid <= 1'b1; loadSel <= TDA_LD_PWM; end
    endcase
    @(posedge clk) {hostLoadWrite, csrWrite, pwmLoadValid} <= 3'h0;
    #1;
    `CHK(todNow_q, v)
  endtask

  task automatic checkRate(input tda_rate_t f, input logic [15:0] m,
                           input logic [15:0] n, input logic [1:0] c,
                           input logic e);
    @(posedge clk);
    rateFamily <= f;
    {rateM, rateN, channelId} <= {m, n, c};
    tick(3);
    `CHK(cycleMode_q, e)
  endtask

  task automatic testRates();
    checkRate(TDA_RATE_500, 16'h2, 16'h1, 2'h2, 1'b1);
    checkRate(TDA_RATE_500, 16'h3, 16'h2, 2'h3, 1'b0);
    checkRate(TDA_RATE_500, 16'h1, 16'h2, 2'h0, 1'b1);
    checkRate(TDA_RATE_500, 16'h1, 16'h0, 2'h0, 1'b1);
    checkRate(TDA_RATE_625, 16'h8, 16'h5, 2'h2, 1'b1);
    checkRate(TDA_RATE_625, 16'h8, 16'h5, 2'h0, 1'b0);
    checkRate(TDA_RATE_625, 16'h108, 16'h105, 2'h0, 1'b1);
    checkRate(TDA_RATE_OTHER, 16'h1, 16'h1, 2'h0, 1'b1);
    checkRate(TDA_RATE_500, 16'h2, 16'h1, 2'h0, 1'b0);
  endtask

  // sub-ns fraction carries into ns; modulus adds one lsb every 2nd cycle
  task automatic testCarry();
    @(posedge clk);
    incSub <= 8'h80;
    {fracNum, fracDen} <= {16'h1, 16'h2};
    loadVia(0, {48'h20, 32'h64, 8'h00});
    tick(1);
    `CHK(todNow_q, {48'h20, 32'h66, 8'h80})
    tick(1);
    `CHK(todNow_q, {48'h20, 32'h69, 8'h01})
    @(posedge clk);
    incSub <= 8'h00;
    {fracNum, fracDen} <= {16'h0, 16'h0};
  endtask

  // ns wrap, pps, pps latch and pwm send-out
  task automatic testWrap();
    @(posedge clk) latchSel <= TDA_LT_PPS;
    loadVia(0, {48'h30, 32'h3B9AC9FE, 8'h00});
    tick(1);
    `CHK(todNow_q, {48'h31, 32'h0, 8'h00})
    `WAIT(ppsOut_q)
    `WAIT(pwmValid_q)
    `CHK(pwmValue_q[87:40], 48'h31)
    tick(3);
    `CHK(latchValue_q[87:40], 48'h31)
    @(posedge clk) latchSel <= TDA_LT_NONE;
  endtask

  // host load then host latch back to back: latch sees loaded value
  task automatic testHostLatch();
    @(posedge clk);
    loadValue <= {48'h40, 32'h10, 8'h00};
    hostLoadWrite <= 1'b1;
    @(posedge clk);
    hostLoadWrite <= 1'b0;
    hostLatchRead <= 1'b1;
    @(posedge clk) hostLatchRead <= 1'b0;
    #1;
    `WAIT(latchValid_q)
    `CHK(latchValue_q, {48'h40, 32'h10, 8'h00})
    @(posedge clk) latchSel <= TDA_LT_CSR;
    @(posedge clk) csrRead <= 1'b1;
    @(posedge clk) csrRead <= 1'b0;
    #1;
    `WAIT(latchValid_q)
    `CHK(latchValue_q, {48'h40, 32'h16, 8'h00})
    @(posedge clk) latchSel <= TDA_LT_NONE;
  endtask

  // gpio, irq and timer latches, then sync capture into the fifo
  task automatic testEvtLatch();
    tda_latch_src_t sel[3];
    sel = '{TDA_LT_GPIO, TDA_LT_IRQ, TDA_LT_GTMR};
    loadVia(0, {48'h50, 32'h0, 8'h00});
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) latchSel <= sel[k];
      shoot(k + 1);
      `WAIT(latchValid_q)
      `CHK(latchValue_q[87:40], 48'h50)
      tick(4);
    end
    @(posedge clk) latchSel <= TDA_LT_SYNC;
    shoot(`TDA_EVT_SYNC);
    `WAIT(fifoCount_q == 3'h1)
    @(posedge clk) fifoPop <= 1'b1;
    @(posedge clk) fifoPop <= 1'b0;
    #1;
    `WAIT(fifoDataValid_q)
    `CHK(fifoData_q[87:40], 48'h50)
    `CHK(fifoCount_q, 3'h0)
    @(posedge clk) latchSel <= TDA_LT_NONE;
  endtask

  // loads from sync edge and global timer
  task automatic testEvtLoad();
    @(posedge clk);
    loadSel <= TDA_LD_SYNC;
    loadValue <= {48'h60, 32'h0, 8'h00};
    shoot(`TDA_EVT_SYNC);
    `WAIT(todNow_q[87:40] == 48'h60)
    `CHK(todNow_q[87:40], 48'h60)
    @(posedge clk);
    loadSel <= TDA_LD_GTMR;
    loadValue <= {48'h70, 32'h0, 8'h00};
    shoot(`TDA_EVT_GTMR);
    `WAIT(todNow_q[87:40] == 48'h70)
    `CHK(todNow_q[87:40], 48'h70)
    @(posedge clk) loadSel <= TDA_LD_NONE;
  endtask

  // cycle counting: sub-ns pinned at zero, 32-bit ns rolls into seconds
  task automatic testCycle();
    @(posedge clk) rateFamily <= TDA_RATE_OTHER;
    tick(3);
    `CHK(cycleMode_q, 1'b1)
    @(posedge clk);
    loadValue <= {48'h1, 32'hFFFFFFFF, 8'h55};
    hostLoadWrite <= 1'b1;
    @(posedge clk) hostLoadWrite <= 1'b0;
    #1;
    `CHK(todNow_q, {48'h1, 32'hFFFFFFFF, 8'h00})
    tick(1);
    `CHK(todNow_q, {48'h2, 32'h0, 8'h00})
    @(posedge clk) rateFamily <= TDA_RATE_500;
  endtask

  // main sequence
  initial begin
    {errorCnt, cmpCount} = 0;
    {arstN, hostLoadWrite, hostLatchRead, csrWrite, csrRead} = 5'h0;
    {pwmLoadValid, fifoPop, fire} = 6'h0;
    rateFamily = TDA_RATE_500;
    {rateM, rateN, fracNum, fracDen} = {16'h2, 16'h1, 16'h0, 16'h0};
    {channelId, incNs, incSub} = {2'h0, 8'h02, 8'h00};
    {loadValue, pwmLoadValue} = {88'h0, 88'h0};
    loadSel = TDA_LD_NONE;
    latchSel = TDA_LT_NONE;
    repeat (4) @(posedge clk);
    #1;
    `CHK(todNow_q, 88'h0)
    `CHK(cycleMode_q, 1'b1)
    @(posedge clk) arstN <= 1'b1;
    testRates();
    for (int k = 0; k < 3; k++) loadVia(k, {48'h10 + k, 32'h64, 8'h03});
    testCarry();
    testWrap();
    testHostLatch();
    testEvtLatch();
    testEvtLoad();
    testCycle();
    stopTest();
  end
endmodule
`default_nettype wire
